// File: hdl/spimsc_clkdiv.sv
// Half-period tick generator for the controller serial clock
module spimsc_clkdiv (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic run,
   input wire logic [6:0] half_cycles,
   output logic tick
);
   logic [6:0] cnt;

   // Restarts from zero each byte so the first edge has a full half period
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt <= 7'h00;
         tick <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            cnt <= 7'h00;
            tick <= 1'b0;
         end else if (cnt == half_cycles - spimsc_pkg::HALF_W1) begin
            cnt <= 7'h00;
            tick <= 1'b1;
         end else begin
            cnt <= cnt + 7'h01;
            tick <= 1'b0;
         end
      end
   end
endmodule : spimsc_clkdiv

// File: hdl/spimsc_core.sv
// Byte-wide controller/target serial port with APB register access
//
// Added by the designer: the APB slave port and the register offsets.

// Summary of operation
// - Power-off bit set holds the whole port inactive.
// - Controller drives MOSI and reads MISO; both shift registers exchange together.
// - Controller never drives select; software uses a general port pin.
// - Controller data write starts the clock generator for eight bits.
// - After the byte the clock stops, done flag sets, interrupt if enabled.
// - Target with select high is idle, MISO released, SCK ignored, loads allowed.
// - Target sets done flag after a full byte under select low.
// - Last received byte sits in a receive buffer until read.
// - Transmit single-buffered; write only after the shift cycle finishes.
// - Receive double-buffered; read before the next byte completes or lose it.
// - Controller forces MISO input; MOSI, SCK, select directions by software.
// - Target forces MOSI, SCK, select input; MISO direction by software.
// - Bit order selects LSB first or MSB first.
// - Target may load the next byte before reading the received one.
// - Rate bits and double bit pick divide 4,16,64,128,2,8,32,64.
// - Done flag clears on vector acknowledge or status read then data access.
// - Data write mid-transfer sets collision; cleared by status read then data access.
// - Select low as input in controller mode drops to target, sets done.
module spimsc_core (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [spimsc_pkg::ADDR_W-1:0] paddr,
   input wire logic [spimsc_pkg::DATA_W-1:0] pwdata,
   output logic [spimsc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_ack,
   output logic transfer_irq,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_n,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_n,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_n,
   input wire logic ss_n_in
);
   logic [7:0] serial_port_control;
   logic transfer_done_flag;
   logic write_collision_flag;
   logic rate_double_bit;
   logic serial_port_power_off;
   logic [3:0] pin_dirs;
   logic [7:0] rx_buf;
   logic [7:0] tx_sr;
   logic [7:0] rx_sr;
   logic out_bit;
   logic [3:0] rx_cnt;
   logic arm_done;
   logic arm_col;
   spimsc_pkg::spimsc_state_e state;
   logic [4:0] edge_cnt;
   logic sck_level;
   logic [spimsc_pkg::SYNC_LAT-1:0] pipe;
   logic sck_s;
   logic sck_q;
   logic ss_s;
   logic mosi_s;
   logic miso_s;
   logic tick;

   // Control field aliases
   logic port_enable_bit;
   logic controller_select_bit;
   logic bit_order_select;
   logic cpol;
   logic cpha;
   logic rate_select_high;
   logic rate_select_low;
   logic transfer_irq_enable;
   assign transfer_irq_enable = serial_port_control[spimsc_pkg::CTRL_IRQ_EN];
   assign port_enable_bit = serial_port_control[spimsc_pkg::CTRL_PORT_EN];
   assign bit_order_select = serial_port_control[spimsc_pkg::CTRL_ORDER];
   assign controller_select_bit = serial_port_control[spimsc_pkg::CTRL_CONTROLLER];
   assign cpol = serial_port_control[spimsc_pkg::CTRL_CPOL];
   assign cpha = serial_port_control[spimsc_pkg::CTRL_CPHA];
   assign rate_select_high = serial_port_control[spimsc_pkg::CTRL_RATE_HI];
   assign rate_select_low = serial_port_control[spimsc_pkg::CTRL_RATE_LO];

   // Mode decode; power-off overrides the enable bit
   logic enabled;
   logic is_ctrl;
   logic is_tgt;
   logic tgt_sel;
   assign enabled = port_enable_bit & ~serial_port_power_off;
   assign is_ctrl = enabled & controller_select_bit;
   assign is_tgt = enabled & ~controller_select_bit;
   assign tgt_sel = is_tgt & ~ss_s;

   // APB decode; a request takes effect at the edge that sees pready high
   logic acc;
   logic wr_ev;
   logic rd_ev;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_data;
   logic hit_power;
   logic hit_pins;
   logic data_acc;
   assign acc = psel & penable & pready;
   assign wr_ev = acc & pwrite;
   assign rd_ev = acc & ~pwrite;
   assign hit_ctrl = (paddr == spimsc_pkg::CTRL_ADDR);
   assign hit_stat = (paddr == spimsc_pkg::STAT_ADDR);
   assign hit_data = (paddr == spimsc_pkg::DATA_ADDR);
   assign hit_power = (paddr == spimsc_pkg::POWER_ADDR);
   assign hit_pins = (paddr == spimsc_pkg::PINS_ADDR);
   assign data_acc = acc & hit_data;

   // Input synchronisers; the engine only looks at the filtered outputs
   spimsc_sync #(.RST_VAL(1'b0)) u_sync_sck (
      .clock(clock), .nrst(nrst), .ce(ce), .pin(sck_in), .stable(sck_s));
   spimsc_sync #(.RST_VAL(1'b1)) u_sync_ss (
      .clock(clock), .nrst(nrst), .ce(ce), .pin(ss_n_in), .stable(ss_s));
   spimsc_sync #(.RST_VAL(1'b0)) u_sync_mosi (
      .clock(clock), .nrst(nrst), .ce(ce), .pin(mosi_in), .stable(mosi_s));
   spimsc_sync #(.RST_VAL(1'b0)) u_sync_miso (
      .clock(clock), .nrst(nrst), .ce(ce), .pin(miso_in), .stable(miso_s));

   // Controller clock divider runs only while edges are being produced
   spimsc_clkdiv u_div (
      .clock(clock),
      .nrst(nrst),
      .ce(ce),
      .run(state == spimsc_pkg::SPIMSC_SHIFT),
      .half_cycles(spimsc_pkg::spimsc_half({rate_double_bit, rate_select_high,
         rate_select_low})),
      .tick(tick)
   );

   // Shift event decode for both roles
   logic active;
   logic load;
   logic ctl_tick;
   logic ctl_sample;
   logic tgt_edge;
   logic tgt_sample;
   logic setup_ev;
   logic sample_ev;
   logic rx_bit;
   logic fin;
   logic fault_ev;
   assign active = (state != spimsc_pkg::SPIMSC_IDLE) | (rx_cnt != 4'h0);
   assign load = wr_ev & hit_data & enabled & ~active;
   assign ctl_tick = tick & (state == spimsc_pkg::SPIMSC_SHIFT);
   // Even edges are leading; cpha moves sampling to the trailing edge
   assign ctl_sample = ctl_tick & (~edge_cnt[0] ^ cpha);
   assign tgt_edge = tgt_sel & (sck_s ^ sck_q);
   assign tgt_sample = tgt_edge & ((sck_s != cpol) ^ cpha);
   assign setup_ev = is_ctrl ? (ctl_tick & ~(~edge_cnt[0] ^ cpha)) : (tgt_edge & ~tgt_sample);
   // Controller samples after the pin pipeline so MISO is seen as at the SCK edge
   assign sample_ev = is_ctrl ? pipe[spimsc_pkg::SYNC_LAT-1] : tgt_sample;
   assign rx_bit = is_ctrl ? miso_s : mosi_s;
   assign fin = (rx_cnt == spimsc_pkg::BITS_PER_BYTE) &
      (~is_ctrl | (state == spimsc_pkg::SPIMSC_DRAIN));
   assign fault_ev = is_ctrl & ~pin_dirs[spimsc_pkg::PIN_SS_OUT] & ~ss_s;

   // Control register; a select fault beats a same-cycle write
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         serial_port_control <= spimsc_pkg::CTRL_RESET;
      end else if (ce) begin
         if (wr_ev && hit_ctrl) begin
            serial_port_control <= pwdata[7:0];
         end
         if (fault_ev) begin
            serial_port_control[spimsc_pkg::CTRL_CONTROLLER] <= 1'b0;
         end
      end
   end

   // Power, pin-direction and rate-double settings
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         serial_port_power_off <= 1'b0;
         pin_dirs <= spimsc_pkg::PINS_RESET;
         rate_double_bit <= 1'b0;
      end else if (ce) begin
         if (wr_ev && hit_power) begin
            serial_port_power_off <= pwdata[spimsc_pkg::POWER_OFF];
         end
         if (wr_ev && hit_pins) begin
            pin_dirs <= pwdata[3:0];
         end
         if (wr_ev && hit_stat) begin
            rate_double_bit <= pwdata[spimsc_pkg::STAT_DOUBLE];
         end
      end
   end

   // Flag clearing is armed by a status read and fired by a data access
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         arm_done <= 1'b0;
         arm_col <= 1'b0;
      end else if (ce) begin
         if (rd_ev && hit_stat) begin
            arm_done <= transfer_done_flag;
            arm_col <= write_collision_flag;
         end else if (data_acc) begin
            arm_done <= 1'b0;
            arm_col <= 1'b0;
         end
      end
   end

   // Sticky flags; a new event in the clearing cycle wins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         transfer_done_flag <= 1'b0;
         write_collision_flag <= 1'b0;
      end else if (ce) begin
         if (fin || fault_ev) begin
            transfer_done_flag <= 1'b1;
         end else if (irq_ack || (data_acc && (arm_done || arm_col))) begin
            transfer_done_flag <= 1'b0;
         end
         if (wr_ev && hit_data && enabled && active) begin
            write_collision_flag <= 1'b1;
         end else if (data_acc && arm_col) begin
            write_collision_flag <= 1'b0;
         end
      end
   end

   // Controller sequencer: sixteen SCK edges, then wait for the last sample
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= spimsc_pkg::SPIMSC_IDLE;
         edge_cnt <= 5'h00;
         sck_level <= 1'b0;
      end else if (ce) begin
         if (!is_ctrl) begin
            state <= spimsc_pkg::SPIMSC_IDLE;
            sck_level <= cpol;
         end else begin
            unique case (state)
               spimsc_pkg::SPIMSC_IDLE: begin
                  sck_level <= cpol;
                  edge_cnt <= 5'h00;
                  if (load) begin
                     state <= spimsc_pkg::SPIMSC_SHIFT;
                  end
               end
               spimsc_pkg::SPIMSC_SHIFT: begin
                  if (tick) begin
                     sck_level <= ~sck_level;
                     edge_cnt <= edge_cnt + 5'h01;
                     if (edge_cnt == spimsc_pkg::LAST_EDGE) begin
                        state <= spimsc_pkg::SPIMSC_DRAIN;
                     end
                  end
               end
               spimsc_pkg::SPIMSC_DRAIN: begin
                  if (fin) begin
                     state <= spimsc_pkg::SPIMSC_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // Sample pipeline matching output register plus input synchroniser delay
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pipe <= '0;
         sck_q <= 1'b0;
      end else if (ce) begin
         pipe <= {pipe[spimsc_pkg::SYNC_LAT-2:0], ctl_sample & is_ctrl};
         sck_q <= sck_s;
      end
   end

   // Transmit side: out_bit changes only on load or setup edges
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tx_sr <= 8'h00;
         out_bit <= 1'b0;
      end else if (ce) begin
         if (load) begin
            // With cpha clear the first bit must sit on the line before the first edge
            out_bit <= bit_order_select ? pwdata[0] : pwdata[7];
            if (cpha) begin
               tx_sr <= pwdata[7:0];
            end else begin
               tx_sr <= bit_order_select ? {1'b0, pwdata[7:1]} : {pwdata[6:0], 1'b0};
            end
         end else if (setup_ev) begin
            out_bit <= bit_order_select ? tx_sr[0] : tx_sr[7];
            tx_sr <= bit_order_select ? {1'b0, tx_sr[7:1]} : {tx_sr[6:0], 1'b0};
         end
      end
   end

   // Receive side; select high in target mode drops a partial byte
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rx_sr <= 8'h00;
         rx_cnt <= 4'h0;
      end else if (ce) begin
         if (!enabled || (is_tgt && ss_s) || fault_ev || fin) begin
            rx_cnt <= 4'h0;
         end else if (sample_ev && rx_cnt != spimsc_pkg::BITS_PER_BYTE) begin
            rx_cnt <= rx_cnt + 4'h1;
            rx_sr <= bit_order_select ? {rx_bit, rx_sr[7:1]} : {rx_sr[6:0], rx_bit};
         end
      end
   end

   // Receive buffer keeps the last whole byte; an unread one is overwritten
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rx_buf <= 8'h00;
      end else if (ce) begin
         if (fin) begin
            rx_buf <= rx_sr;
         end
      end
   end

   // Pin drivers and direction overrides; oe_n low means this block drives
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sck_out <= 1'b0;
         sck_oe_n <= 1'b1;
         mosi_out <= 1'b0;
         mosi_oe_n <= 1'b1;
         miso_out <= 1'b0;
         miso_oe_n <= 1'b1;
      end else if (ce) begin
         sck_out <= is_ctrl ? sck_level : cpol;
         sck_oe_n <= ~(is_ctrl & pin_dirs[spimsc_pkg::PIN_SCK_DRV]);
         mosi_out <= out_bit;
         mosi_oe_n <= ~(is_ctrl & pin_dirs[spimsc_pkg::PIN_MOSI_DRV]);
         miso_out <= out_bit;
         // Released while select is high so several targets can share MISO
         miso_oe_n <= ~(tgt_sel & pin_dirs[spimsc_pkg::PIN_MISO_DRV]);
      end
   end

   // Interrupt request level for the system controller
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         transfer_irq <= 1'b0;
      end else if (ce) begin
         transfer_irq <= transfer_done_flag & transfer_irq_enable;
      end
   end

   // Read mux
   logic [spimsc_pkg::DATA_W-1:0] rd_val;
   logic rd_hit;
   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      if (hit_ctrl) begin
         rd_val[7:0] = serial_port_control;
      end else if (hit_stat) begin
         rd_val[spimsc_pkg::STAT_DONE] = transfer_done_flag;
         rd_val[spimsc_pkg::STAT_COL] = write_collision_flag;
         rd_val[spimsc_pkg::STAT_DOUBLE] = rate_double_bit;
      end else if (hit_data) begin
         rd_val[7:0] = rx_buf;
      end else if (hit_power) begin
         rd_val[spimsc_pkg::POWER_OFF] = serial_port_power_off;
      end else if (hit_pins) begin
         rd_val[3:0] = pin_dirs;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // APB answer: one wait state, then pready with data and error
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? '0 : rd_val;
            pslverr <= ~rd_hit;
         end else begin
            prdata <= '0;
            pslverr <= 1'b0;
         end
      end
   end
endmodule : spimsc_core

// File: hdl/spimsc_sync.sv
// Three-stage input synchroniser with agreement filter
module spimsc_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic pin,
   output logic stable
);
   logic s1;
   logic s2;
   logic s3;

   // Stage one feeds stage two only; the value moves once two and three agree
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         stable <= RST_VAL;
      end else if (ce) begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            stable <= s3;
         end
      end
   end
endmodule : spimsc_sync

// File: include/spimsc_pkg.sv
// Constants, register map and state encoding for the byte-wide serial port core
package spimsc_pkg;
   // APB widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Register indexes; byte address is four times the index
   localparam logic [7:0] CTRL_IDX = 8'h2c;
   localparam logic [7:0] STAT_IDX = 8'h2d;
   localparam logic [7:0] DATA_IDX = 8'h2e;
   localparam logic [7:0] POWER_IDX = 8'h30;
   localparam logic [7:0] PINS_IDX = 8'h31;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] POWER_ADDR = {2'h0, POWER_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] PINS_ADDR = {2'h0, PINS_IDX, 2'h0};
   // Control register fields
   localparam int CTRL_IRQ_EN = 7;
   localparam int CTRL_PORT_EN = 6;
   localparam int CTRL_ORDER = 5;
   localparam int CTRL_CONTROLLER = 4;
   localparam int CTRL_CPOL = 3;
   localparam int CTRL_CPHA = 2;
   localparam int CTRL_RATE_HI = 1;
   localparam int CTRL_RATE_LO = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Status register fields
   localparam int STAT_DONE = 7;
   localparam int STAT_COL = 6;
   localparam int STAT_DOUBLE = 0;
   // Power and pin-direction register fields
   localparam int POWER_OFF = 0;
   localparam int PIN_MOSI_DRV = 0;
   localparam int PIN_SCK_DRV = 1;
   localparam int PIN_MISO_DRV = 2;
   localparam int PIN_SS_OUT = 3;
   localparam logic [3:0] PINS_RESET = 4'h0;
   // Shift sequencing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [4:0] LAST_EDGE = 5'h0f;
   localparam int SYNC_LAT = 5;
   localparam logic [6:0] HALF_W1 = 7'h01;
   // Controller sequencer
   typedef enum logic [1:0] {
      SPIMSC_IDLE = 2'b00,
      SPIMSC_SHIFT = 2'b01,
      SPIMSC_DRAIN = 2'b11
   } spimsc_state_e;
   // Half period of SCK in clock cycles for {double, rate_hi, rate_lo}
   function automatic logic [6:0] spimsc_half(input logic [2:0] sel);
      logic [6:0] h;
      h = 7'h02;
      unique case (sel)
         3'h0: h = 7'h02;
         3'h1: h = 7'h08;
         3'h2: h = 7'h20;
         3'h3: h = 7'h40;
         3'h4: h = 7'h01;
         3'h5: h = 7'h04;
         3'h6: h = 7'h10;
         3'h7: h = 7'h20;
      endcase
      return h;
   endfunction : spimsc_half
endpackage : spimsc_pkg

// File: test/spimsc_core_tb.sv
// Self-checking bench for the serial port core
module spimsc_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic irq_ack = 1'b0;
   logic ss_n_in = 1'b1;
   logic far_sck = 1'b0, far_mosi = 1'b0;
   logic lsb = 1'b0;
   logic [7:0] far_tx = 8'h00;
   logic [31:0] prdata, q;
   logic pready, pslverr, transfer_irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, err;
   logic miso_out, miso_oe_n, far_miso, far_oe;
   logic [7:0] far_rx;
   int fail_count = 0;
   int n_tests = 0;
   int halves[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   // Undriven sck and mosi follow the far controller; miso pulled up
   wire logic sck_in = sck_oe_n ? far_sck : sck_out;
   wire logic mosi_in = mosi_oe_n ? far_mosi : mosi_out;
   wire logic miso_in = !miso_oe_n ? miso_out : (far_oe ? far_miso : 1'b1);
   always #5 clock = !clock;
   spimsc_core i_spimsc_core (.*);
   spimsc_target_model i_spimsc_target_model (.sck(sck_in), .mosi(mosi_in), .ss_n(ss_n_in),
      .lsb_first(lsb), .tx_byte(far_tx), .miso(far_miso), .miso_oe(far_oe), .rx_byte(far_rx));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; waits for pready, no assumed latency
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Select is a general pin here, so the bench lowers it itself
   task automatic start(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] ftx);
      far_tx = ftx;
      lsb = ctl[5];
      apb(1'b1, spimsc_pkg::PINS_ADDR, 32'hb);
      apb(1'b1, spimsc_pkg::CTRL_ADDR, {24'h0, ctl});
      ss_n_in <= 1'b0;
      apb(1'b1, spimsc_pkg::DATA_ADDR, {24'h0, tx});
   endtask : start
   task automatic wait_done;
      q = 32'h0;
      for (int i = 0; i < 3000 && q[7] !== 1'b1; i++) apb(1'b0, spimsc_pkg::STAT_ADDR, 32'h0);
      chk(32'(q[7]), 32'h1);
   endtask : wait_done
   task automatic t_reset;
      chk(32'({sck_oe_n, mosi_oe_n, miso_oe_n}), 32'h7);
      apb(1'b0, spimsc_pkg::CTRL_ADDR, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk({q[30:0], err}, 32'h1);
   endtask : t_reset
   task automatic t_xfer(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] ftx);
      start(ctl, tx, ftx);
      wait_done;
      apb(1'b0, spimsc_pkg::DATA_ADDR, 32'h0);
      chk(q, {24'h0, ftx});
      chk({24'h0, far_rx}, {24'h0, tx});
      apb(1'b0, spimsc_pkg::STAT_ADDR, 32'h0);
      chk(q, 32'h0);
      ss_n_in <= 1'b1;
   endtask : t_xfer
   // Second write lands mid-byte and must not replace the byte in flight
   task automatic t_collide;
      start(8'hd1, 8'h33, 8'hcc);
      apb(1'b1, spimsc_pkg::DATA_ADDR, 32'h55);
      for (int i = 0; i < 3000 && transfer_irq !== 1'b1; i++) @(posedge clock);
      chk(32'(transfer_irq), 32'h1);
      irq_ack <= 1'b1;
      @(posedge clock);
      irq_ack <= 1'b0;
      apb(1'b0, spimsc_pkg::STAT_ADDR, 32'h0);
      chk(q, 32'h40);
      apb(1'b0, spimsc_pkg::DATA_ADDR, 32'h0);
      chk(q, 32'hcc);
      chk(32'(far_rx), 32'h33);
      apb(1'b0, spimsc_pkg::STAT_ADDR, 32'h0);
      chk(q, 32'h0);
      ss_n_in <= 1'b1;
   endtask : t_collide
   task automatic t_power;
      apb(1'b1, spimsc_pkg::POWER_ADDR, 32'h1);
      start(8'h51, 8'h77, 8'h00);
      repeat (50) @(posedge clock);
      chk(32'(sck_oe_n), 32'h1);
      apb(1'b0, spimsc_pkg::STAT_ADDR, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, spimsc_pkg::POWER_ADDR, 32'h0);
      ss_n_in <= 1'b1;
   endtask : t_power
   // Half period of sck for every divider code
   task automatic t_rates;
      int h;
      logic s;
      for (int r = 0; r < 8; r++) begin
         apb(1'b1, spimsc_pkg::STAT_ADDR, 32'(r[2]));
         start(8'h50 | 8'(r[1:0]), 8'h0f, 8'hf0);
         h = 0;
         s = sck_out;
         while (sck_out === s) @(posedge clock);
         s = sck_out;
         while (sck_out === s) begin
            @(posedge clock);
            h++;
         end
         chk(32'(h), 32'(halves[r]));
         wait_done;
         apb(1'b0, spimsc_pkg::DATA_ADDR, 32'h0);
         chk(q, 32'hf0);
         chk(32'(far_rx), 32'h0f);
         ss_n_in <= 1'b1;
      end
      apb(1'b1, spimsc_pkg::STAT_ADDR, 32'h0);
   endtask : t_rates
   // Select low as input drops to target; then release of select
   task automatic t_target;
      apb(1'b1, spimsc_pkg::PINS_ADDR, 32'h3);
      apb(1'b1, spimsc_pkg::CTRL_ADDR, 32'h51);
      ss_n_in <= 1'b0;
      repeat (8) @(posedge clock);
      apb(1'b0, spimsc_pkg::CTRL_ADDR, 32'h0);
      chk(q, 32'h41);
      apb(1'b0, spimsc_pkg::STAT_ADDR, 32'h0);
      chk(q, 32'h80);
      apb(1'b1, spimsc_pkg::PINS_ADDR, 32'h4);
      repeat (8) @(posedge clock);
      chk(32'({sck_oe_n, mosi_oe_n, miso_oe_n}), 32'h6);
      ss_n_in <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(miso_oe_n), 32'h1);
   endtask : t_target
   // Far controller runs mode 0 with phases of eight clocks, well over two
   task automatic t_slave(input logic [7:0] tx, input logic [7:0] ftx);
      logic [7:0] got;
      apb(1'b1, spimsc_pkg::CTRL_ADDR, 32'h40);
      apb(1'b1, spimsc_pkg::DATA_ADDR, {24'h0, tx});
      ss_n_in <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         far_mosi <= ftx[i];
         repeat (8) @(posedge clock);
         got[i] = miso_out;
         far_sck <= 1'b1;
         repeat (8) @(posedge clock);
         far_sck <= 1'b0;
      end
      wait_done;
      apb(1'b0, spimsc_pkg::DATA_ADDR, 32'h0);
      chk(q, {24'h0, ftx});
      chk({24'h0, got}, {24'h0, tx});
      ss_n_in <= 1'b1;
   endtask : t_slave
   task automatic test_done;
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      t_reset;
      t_xfer(8'h51, 8'ha5, 8'h3c);
      t_xfer(8'h71, 8'h1e, 8'h6a);
      t_collide;
      t_power;
      t_rates;
      t_target;
      t_slave(8'h96, 8'h5a);
      test_done;
   end
   // Watchdog well above the longest divider run
   initial begin
      #400000;
      fail_count++;
      test_done;
   end
endmodule : spimsc_core_tb
bind spimsc_core spimsc_properties i_spimsc_properties (.*);

// File: test/spimsc_properties.sv
// Port-level checker for the serial port core
module spimsc_properties (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [spimsc_pkg::DATA_W-1:0] prdata,
   input wire logic irq_ack,
   input wire logic transfer_irq,
   input wire logic sck_out,
   input wire logic sck_oe_n,
   input wire logic mosi_out,
   input wire logic mosi_oe_n,
   input wire logic miso_oe_n,
   input wire logic ss_n_in
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // Bus access: one wait state, then a one-cycle answer
   sequence s_access;
      psel && $rose(penable);
   endsequence
   sequence s_answer;
      ##1 pready ##1 !pready;
   endsequence
   a_one_wait: assert property (s_access |-> s_answer)
      else $error("pready not a single pulse after one wait");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == '0)
      else $error("prdata not zero outside answer");
   a_miso_in_ctrl: assert property (!sck_oe_n |-> miso_oe_n)
      else $error("miso driven while driving sck");
   a_target_inputs: assert property (!miso_oe_n |-> sck_oe_n && mosi_oe_n)
      else $error("target drives sck or mosi");
   // Sync latency allowance before the pin is released
   a_miso_idle: assert property (ss_n_in [*6] |-> miso_oe_n)
      else $error("miso driven while deselected");
   a_mosi_steady: assert property ($rose(sck_out) |-> $stable(mosi_out))
      else $error("mosi moved on sample edge");
   a_irq_clear: assert property (irq_ack ##1 !irq_ack |-> ##1 !transfer_irq)
      else $error("interrupt not cleared by acknowledge");
endmodule : spimsc_properties

// File: test/spimsc_target_model.sv
// Behavioural mode-0 target on the far side of the serial link
module spimsc_target_model (
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   input wire logic lsb_first,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic miso_oe,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh = 8'h00;
   logic bit_in = 1'b0;
   // Load on select; drive only while selected
   always @(negedge ss_n) sh = tx_byte;
   assign miso_oe = !ss_n;
   assign miso = lsb_first ? sh[0] : sh[7];
   assign rx_byte = sh;
   // Sample on rising edge, shift on falling so both registers swap
   always @(posedge sck) if (!ss_n) bit_in = mosi;
   always @(negedge sck) begin
      if (!ss_n) begin
         sh = lsb_first ? {bit_in, sh[7:1]} : {sh[6:0], bit_in};
      end
   end
endmodule : spimsc_target_model
